//--- design/wdt_sleep_ctrl.sv
// watchdog, sleep entry and wake-up control with ahb-lite registers
//
// What this block does
// - clear watchdog on disable, instruction, osc fail, wake
// - crystal wake holds watchdog clear through start-up
// - period code doubles ratio, 1:32 to 1:65536
// - period field resets to code 0100
// - bit 0 software enable, resets off
// - fuse set forces watchdog on
// - control bits 7 to 5 read zero
// - sleep clears watchdog, pd, sets to, osc off
// - io pins hold their drive during sleep
// - watchdog reset is internal, pin untouched
// - pin wake resets, other wakes continue
// - pd set at power-up, to cleared on wdt wake
// - prefetch next instruction during sleep
// - interrupt wake needs own enable, ignores global
// - global enable picks continue or vector
// - pending interrupt makes sleep a no-operation
// - interrupt during sleep completes sleep, wakes
// - every wake-up clears the watchdog
// - clocks stop, only listed sources wake
// - time base from 31 khz low-frequency oscillator; here mclk divided down by 1290
// - watchdog held while start-up timer counts
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module wdt_sleep_ctrl import wdsl_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // core events and interrupt state
  input wire logic sleep_instr_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic osc_fail_i,
  input wire logic crystal_mode_i,
  input wire logic global_irq_enable_i,
  input wire logic [7:0] irq_enable_i,
  input wire logic [7:0] irq_flag_i,
  input wire io_drive_s io_i,
  // pins
  input wire logic master_clear_pin_i,
  input wire logic config_watchdog_force_i,
  // control outputs
  output logic core_run_o,
  output logic osc_driver_en_o,
  output logic device_reset_o,
  output logic wake_continue_o,
  output logic vector_after_next_o,
  output logic prefetch_next_o,
  output logic power_down_flag_o,
  output logic wdt_expiry_flag_o,
  output io_drive_s io_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pwr_state_e st;
    logic [4:0] wdt_ctl;
    logic [7:0] option;
    logic pd;
    logic to;
    logic dp_wr;
    logic [9:0] dp_idx;
    logic [31:0] rdata;
    logic [10:0] lf_div;
    logic lf_tick;
    logic [9:0] ost_cnt;
    logic vec_pend;
    logic wdt_clr;
    logic rst;
    logic wake;
    logic vec;
    logic prefetch;
    logic osc_en;
    logic run;
    io_drive_s io;
  } ctl_state_s;

  ctl_state_s s;
  ctl_state_s next_s;
  logic [1:0] pin_sync;
  logic master_clear_pin_low;
  logic force_on;
  logic wdt_en;
  logic irq_pend;
  logic wdt_expire;
  logic [15:0] wdt_count;
  logic addr_ok;

  bit_sync2 #(.W(2)) u_pin_sync (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .async_i({master_clear_pin_i, config_watchdog_force_i}),
    .sync_o(pin_sync)
  );

  assign master_clear_pin_low = !pin_sync[1];
  assign force_on = pin_sync[0];
  assign wdt_en = force_on || s.wdt_ctl[CTL_SWEN_BIT];
  // the irq vector holds only the eight sleep-capable sources
  assign irq_pend = |(irq_enable_i & irq_flag_i);
  assign addr_ok = hsel_i && htrans_i[1] && hready_i;

  wdt_counter u_wdt (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .tick_i(s.lf_tick),
    .clear_i(s.wdt_clr),
    .run_i(wdt_en && s.st != ST_OST),
    .period_sel_i(s.wdt_ctl[CTL_PSEL_MSB:CTL_PSEL_LSB]),
    .expire_o(wdt_expire),
    .count_o(wdt_count)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.rst = master_clear_pin_low;
    next_s.wake = 1'b0;
    next_s.vec = 1'b0;
    next_s.prefetch = 1'b0;
    next_s.lf_tick = 1'b0;
    // low-frequency time base
    if (s.lf_div == LF_DIV_M1) begin
      next_s.lf_div = '0;
      next_s.lf_tick = 1'b1;
    end else begin
      next_s.lf_div = s.lf_div + 11'h001;
    end
    // the clear is registered, so the count drops two cycles after its cause
    next_s.wdt_clr = !wdt_en || clear_watchdog_instr_i || osc_fail_i;
    // register writes land in the data phase
    if (s.dp_wr) begin
      case (s.dp_idx)
        IDX_WDT_CTL: next_s.wdt_ctl = hwdata_i[4:0];
        IDX_OPTION: next_s.option = hwdata_i[7:0];
        default: next_s.option = next_s.option;
      endcase
    end
    next_s.dp_wr = addr_ok && hwrite_i;
    if (addr_ok) begin
      next_s.dp_idx = haddr_i[11:2];
    end
    case (s.st)
      ST_AWAKE: begin
        next_s.io = io_i;
        // an awake overflow wins over a sleep request in the same cycle
        if (wdt_expire) begin
          next_s.rst = 1'b1;
          next_s.to = 1'b0;
        end else if (sleep_instr_i && !irq_pend) begin
          next_s.st = ST_SLEEP;
          next_s.wdt_clr = 1'b1;
          next_s.pd = 1'b0;
          next_s.to = 1'b1;
          next_s.osc_en = 1'b0;
          next_s.prefetch = 1'b1;
        end
      end
      ST_SLEEP: begin
        // io state frozen from the last awake cycle
        next_s.io = s.io;
        if (master_clear_pin_low) begin
          next_s.st = ST_AWAKE;
          next_s.wdt_clr = 1'b1;
          next_s.osc_en = 1'b1;
        end else if (wdt_expire || irq_pend) begin
          if (wdt_expire) begin
            next_s.to = 1'b0;
          end
          next_s.vec_pend = !wdt_expire && global_irq_enable_i;
          next_s.wdt_clr = 1'b1;
          next_s.osc_en = 1'b1;
          next_s.ost_cnt = '0;
          if (crystal_mode_i) begin
            next_s.st = ST_OST;
          end else begin
            next_s.st = ST_AWAKE;
            next_s.wake = 1'b1;
            next_s.vec = next_s.vec_pend;
          end
        end
      end
      ST_OST: begin
        next_s.io = s.io;
        next_s.wdt_clr = 1'b1;
        if (master_clear_pin_low) begin
          next_s.st = ST_AWAKE;
        end else if (s.lf_tick) begin
          if (s.ost_cnt == OST_TICKS_M1) begin
            next_s.st = ST_AWAKE;
            next_s.wake = 1'b1;
            next_s.vec = s.vec_pend;
          end else begin
            next_s.ost_cnt = s.ost_cnt + 10'h001;
          end
        end
      end
      default: begin
        next_s.st = ST_AWAKE;
      end
    endcase
    next_s.run = (next_s.st == ST_AWAKE);
    // read data forwarded from the updated registers
    if (addr_ok && !hwrite_i) begin
      case (haddr_i[11:2])
        IDX_WDT_CTL: next_s.rdata = {27'h0, next_s.wdt_ctl};
        IDX_OPTION: next_s.rdata = {24'h0, next_s.option};
        IDX_STATUS: next_s.rdata = {27'h0, wdt_en, next_s.st, next_s.to, next_s.pd};
        default: next_s.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s <= '0;
      s.st <= ST_AWAKE;
      s.wdt_ctl <= CTL_RST;
      s.option <= OPTION_RST;
      s.pd <= 1'b1;
      s.to <= 1'b1;
      s.wdt_clr <= 1'b1;
      s.osc_en <= 1'b1;
      s.run <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hrdata_o = s.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign core_run_o = s.run;
  assign osc_driver_en_o = s.osc_en;
  assign device_reset_o = s.rst;
  assign wake_continue_o = s.wake;
  assign vector_after_next_o = s.vec;
  assign prefetch_next_o = s.prefetch;
  assign power_down_flag_o = s.pd;
  assign wdt_expiry_flag_o = s.to;
  assign io_o = s.io;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  chk_clr_instr_zero: assert property (clear_watchdog_instr_i |-> ##2 wdt_count == 16'h0)
    else $error("clear instruction did not zero the watchdog");
  chk_ost_holds_wdt: assert property ((s.st == ST_OST) [*3] |-> wdt_count == 16'h0)
    else $error("watchdog counted during start-up");
  chk_ctl_reset_val: assert property (@(posedge mclk_i) disable iff (1'b0)
    srst_i |=> s.wdt_ctl == CTL_RST)
    else $error("control register reset value wrong");
  chk_ctl_read_zero: assert property (addr_ok && !hwrite_i && haddr_i[11:2] == IDX_WDT_CTL
    |=> hrdata_o[31:5] == 27'h0)
    else $error("unimplemented control bits read nonzero");
  chk_sleep_entry: assert property ($rose(s.st == ST_SLEEP) |-> !power_down_flag_o &&
    wdt_expiry_flag_o && !osc_driver_en_o && prefetch_next_o)
    else $error("sleep entry did not update flags");
  chk_io_frozen: assert property (s.st == ST_SLEEP && $past(s.st) == ST_SLEEP |-> $stable(io_o))
    else $error("io drive changed during sleep");
  chk_nop_sleep: assert property (s.st == ST_AWAKE && sleep_instr_i && irq_pend && !wdt_expire
    |=> s.st == ST_AWAKE && $stable(power_down_flag_o) && $stable(wdt_expiry_flag_o))
    else $error("sleep with pending interrupt was not a no-op");
  chk_pin_wake_reset: assert property (s.st == ST_SLEEP && master_clear_pin_low
    |=> device_reset_o && !wake_continue_o)
    else $error("pin wake did not reset");
  chk_wdt_wake_to: assert property (s.st == ST_SLEEP && wdt_expire |=> !wdt_expiry_flag_o
    ##1 wdt_count == 16'h0)
    else $error("watchdog wake flag or clear wrong");
  chk_awake_overflow: assert property (s.st == ST_AWAKE && wdt_expire |=> device_reset_o)
    else $error("awake overflow did not reset");
  chk_irq_vector: assert property (s.st == ST_SLEEP && !master_clear_pin_low && !wdt_expire && irq_pend
    && !crystal_mode_i |=> wake_continue_o && vector_after_next_o == $past(global_irq_enable_i))
    else $error("interrupt wake vector choice wrong");

  chk_off_clears_wdt: assert property ((!wdt_en || osc_fail_i)
    |-> ##2 wdt_count == 16'h0)
    else $error("disabled or failed watchdog was not cleared");
  chk_sleep_prefetch: assert property (s.st == ST_AWAKE && sleep_instr_i && !irq_pend && !wdt_expire
    |=> prefetch_next_o && !core_run_o)
    else $error("accepted sleep did not prefetch or stop the core");
  chk_prefetch_pulse: assert property (prefetch_next_o
    |=> !prefetch_next_o)
    else $error("prefetch request longer than one cycle");
  chk_reset_flags: assert property (@(posedge mclk_i) disable iff (1'b0)
    srst_i |=> power_down_flag_o && wdt_expiry_flag_o)
    else $error("status flags wrong after reset");
  chk_pd_only_sleep: assert property ($fell(power_down_flag_o)
    |-> $rose(s.st == ST_SLEEP))
    else $error("power-down flag cleared outside sleep entry");
  chk_to_only_sleep: assert property ($rose(wdt_expiry_flag_o)
    |-> $rose(s.st == ST_SLEEP))
    else $error("expiry flag set outside sleep entry");
  chk_osc_off_sleep: assert property (s.st == ST_SLEEP
    |-> !osc_driver_en_o)
    else $error("oscillator driver on during sleep");
  chk_io_follow_awake: assert property (s.st == ST_AWAKE
    |=> io_o == $past(io_i))
    else $error("io drive not tracking the core while awake");
  chk_irq_needs_en: assert property (s.st == ST_SLEEP && !master_clear_pin_low && !wdt_expire && !irq_pend
    |=> s.st == ST_SLEEP && !wake_continue_o)
    else $error("woke without an enabled interrupt");
  chk_vec_with_wake: assert property (vector_after_next_o
    |-> wake_continue_o)
    else $error("vector request without a wake");
  chk_wake_clears_wdt: assert property (wake_continue_o
    |-> ##1 wdt_count == 16'h0)
    else $error("wake did not clear the watchdog");
  chk_wdt_wake_novec: assert property (s.st == ST_SLEEP && !master_clear_pin_low && wdt_expire && !crystal_mode_i
    |=> wake_continue_o && !vector_after_next_o && !device_reset_o)
    else $error("sleep overflow did not wake without vector");

  cov_sleep_enter: cover property ($rose(s.st == ST_SLEEP));
  cov_ost_wake: cover property (s.st == ST_OST ##1 wake_continue_o);
  cov_wdt_wake: cover property (s.st == ST_SLEEP && wdt_expire);
  cov_nop_sleep: cover property (s.st == ST_AWAKE && sleep_instr_i && irq_pend);
  cov_awake_reset: cover property (s.st == ST_AWAKE && wdt_expire);

endmodule : wdt_sleep_ctrl

//--- design/wdsl_pkg.sv
// shared constants and types for the watchdog and sleep/wake block
package wdsl_pkg;

  // ----------------------------------------
  // clocking
  // ----------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int LF_HZ = 31000;
  localparam logic [10:0] LF_DIV_M1 = 11'(CLK_HZ / LF_HZ - 1);
  // start-up delay in low-frequency ticks, value is a plain default
  localparam logic [9:0] OST_TICKS_M1 = 10'h3ff;

  // ----------------------------------------
  // register map (printed offsets are word indexes)
  // ----------------------------------------
  localparam logic [9:0] IDX_WDT_CTL = 10'h018;
  localparam logic [9:0] IDX_OPTION = 10'h081;
  localparam logic [9:0] IDX_STATUS = 10'h082;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int CTL_SWEN_BIT = 0;
  localparam int CTL_PSEL_LSB = 1;
  localparam int CTL_PSEL_MSB = 4;
  localparam logic [4:0] CTL_RST = 5'h08;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [3:0] PSEL_MAX = 4'hb;
  localparam int PSEL_BASE_LOG2 = 5;
  localparam int IO_W = 6;

  // ----------------------------------------
  // power state
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_AWAKE = 2'b00,
    ST_SLEEP = 2'b01,
    ST_OST = 2'b10
  } pwr_state_e;

  typedef struct packed {
    logic [IO_W-1:0] out;
    logic [IO_W-1:0] oe;
  } io_drive_s;

endpackage : wdsl_pkg

//--- design/bit_sync2.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module bit_sync2 import wdsl_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_s;

  sync_state_s s;
  sync_state_s next_s;

  always_comb begin
    next_s.meta = async_i;
    next_s.sync = s.meta;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_o = s.sync;

endmodule : bit_sync2

//--- design/wdt_counter.sv
// watchdog synchronous tick counter with period select
`timescale 1ns/1ps
module wdt_counter import wdsl_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // control
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic run_i,
  input wire logic [3:0] period_sel_i,
  // status
  output logic expire_o,
  output logic [15:0] count_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic expire;
  } cnt_state_s;

  cnt_state_s s;
  cnt_state_s next_s;
  logic [3:0] psel;
  logic [15:0] term;

  // reserved codes fall back to the longest period
  assign psel = (period_sel_i > PSEL_MAX) ? PSEL_MAX : period_sel_i;
  assign term = 16'((32'd1 << (PSEL_BASE_LOG2 + 32'(psel))) - 32'd1);

  always_comb begin
    next_s = s;
    next_s.expire = 1'b0;
    if (clear_i) begin
      next_s.cnt = '0;
    end else if (run_i && tick_i) begin
      if (s.cnt >= term) begin
        next_s.cnt = '0;
        next_s.expire = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign expire_o = s.expire;
  assign count_o = s.cnt;

  chk_expire_at_term: assert property (@(posedge mclk_i) disable iff (srst_i)
    $rose(s.expire) |-> $past(s.cnt) >= $past(term))
    else $error("watchdog expired before its period");

endmodule : wdt_counter

//--- bench/watchdog_sleep_wake_control_tb.sv
// self-checking bench for the watchdog and sleep/wake block
`timescale 1ns/1ps
module watchdog_sleep_wake_control_tb;
  import wdsl_pkg::*;

  // ----------------------------------------
  // signals and constants
  // ----------------------------------------
  localparam logic [31:0] A_CTL = 32'(IDX_WDT_CTL) << 2;
  localparam logic [31:0] A_OPT = 32'(IDX_OPTION) << 2;
  localparam logic [31:0] A_STS = 32'(IDX_STATUS) << 2;
  localparam int TICK = int'(LF_DIV_M1) + 1;
  logic mclk_i, srst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic sleep_instr_i, clear_watchdog_instr_i, osc_fail_i, crystal_mode_i, global_irq_enable_i;
  logic [7:0] irq_enable_i, irq_flag_i;
  io_drive_s io_i, io_o;
  logic master_clear_pin_i, config_watchdog_force_i;
  logic core_run_o, osc_driver_en_o, device_reset_o, wake_continue_o, vector_after_next_o;
  logic prefetch_next_o, power_down_flag_o, wdt_expiry_flag_o;
  int fail_count, checks_done, n;

  wdt_sleep_ctrl DUT (
    .mclk_i(mclk_i), .srst_i(srst_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .sleep_instr_i(sleep_instr_i), .clear_watchdog_instr_i(clear_watchdog_instr_i),
    .osc_fail_i(osc_fail_i), .crystal_mode_i(crystal_mode_i),
    .global_irq_enable_i(global_irq_enable_i), .irq_enable_i(irq_enable_i),
    .irq_flag_i(irq_flag_i), .io_i(io_i), .master_clear_pin_i(master_clear_pin_i),
    .config_watchdog_force_i(config_watchdog_force_i), .core_run_o(core_run_o),
    .osc_driver_en_o(osc_driver_en_o), .device_reset_o(device_reset_o),
    .wake_continue_o(wake_continue_o), .vector_after_next_o(vector_after_next_o),
    .prefetch_next_o(prefetch_next_o), .power_down_flag_o(power_down_flag_o),
    .wdt_expiry_flag_o(wdt_expiry_flag_o), .io_o(io_o)
  );

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic timeout;
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    finish_test();
  endtask : timeout

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // waits for hready, never assuming a cycle count
  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 20);
    if (hreadyout_o !== 1'b1) begin
      timeout();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] r);
    @(posedge mclk_i);
    htrans_i <= 2'b10;
    haddr_i <= addr;
    hwrite_i <= wr;
    wait_ready();
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    wait_ready();
    r = hrdata_o;
  endtask : bus

  task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
    logic [31:0] r;
    bus(1'b1, addr, wd, r);
  endtask : wr

  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, addr, 32'h0, r);
    check(r, exp);
    check(32'(hresp_o), 32'h0);
  endtask : rd_chk

  // one-cycle sleep pulse; returns just after the taking edge has settled
  task automatic enter_sleep;
    @(posedge mclk_i);
    sleep_instr_i <= 1'b1;
    @(posedge mclk_i);
    sleep_instr_i <= 1'b0;
    #1;
  endtask : enter_sleep

  // which 0: wake pulse, which 1: device reset
  task automatic wait_sig(input int which, input int bound, output int k);
    logic hit;
    k = 0;
    hit = 1'b0;
    while (!hit) begin
      @(posedge mclk_i);
      #1;
      k++;
      hit = (which == 0) ? (wake_continue_o === 1'b1) : (device_reset_o === 1'b1);
      if (!hit && k >= bound) begin
        timeout();
      end
    end
  endtask : wait_sig

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    fail_count = 0;
    checks_done = 0;
    srst_i = 1'b1;
    hsel_i = 1'b1;
    haddr_i = 32'h0;
    htrans_i = 2'b00;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    sleep_instr_i = 1'b0;
    clear_watchdog_instr_i = 1'b0;
    osc_fail_i = 1'b0;
    crystal_mode_i = 1'b0;
    global_irq_enable_i = 1'b0;
    irq_enable_i = 8'h00;
    irq_flag_i = 8'h00;
    io_i = '{out: 6'h2a, oe: 6'h0f};
    master_clear_pin_i = 1'b1;
    config_watchdog_force_i = 1'b0;
    repeat (12) @(posedge mclk_i);
    srst_i <= 1'b0;
    // pin synchronisers need a few edges to flush
    repeat (4) @(posedge mclk_i);
    rd_chk(A_CTL, 32'h08);
    rd_chk(A_OPT, 32'hff);
    rd_chk(A_STS, 32'h03);
    wr(A_CTL, 32'hff);
    rd_chk(A_CTL, 32'h1f);
    wr(A_OPT, 32'h5a);
    rd_chk(A_OPT, 32'h5a);
    wr(32'h0, 32'hff);
    rd_chk(32'h0, 32'h0);
    wr(A_CTL, 32'h08);
    rd_chk(A_STS, 32'h03);
    @(posedge mclk_i);
    config_watchdog_force_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd_chk(A_STS, 32'h13);
    @(posedge mclk_i);
    config_watchdog_force_i <= 1'b0;
    irq_enable_i <= 8'h01;
    irq_flag_i <= 8'h01;
    repeat (3) @(posedge mclk_i);
    enter_sleep();
    check(prefetch_next_o, 1'b0);
    check(core_run_o, 1'b1);
    check(power_down_flag_o, 1'b1);
    // every sleep-capable source, alternating the global enable
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_i);
      irq_flag_i <= 8'h00;
      irq_enable_i <= 8'h00;
      global_irq_enable_i <= i[0];
      enter_sleep();
      check(prefetch_next_o, 1'b1);
      check(power_down_flag_o, 1'b0);
      check(wdt_expiry_flag_o, 1'b1);
      check(osc_driver_en_o, 1'b0);
      check(core_run_o, 1'b0);
      @(posedge mclk_i);
      io_i <= '{out: 6'h15, oe: 6'h30};
      irq_flag_i <= 8'(1 << i);
      repeat (4) @(posedge mclk_i);
      #1;
      check(32'(io_o), 32'h00000a8f);
      check(core_run_o, 1'b0);
      @(posedge mclk_i);
      irq_enable_i <= 8'(1 << i);
      wait_sig(0, 20, n);
      check(vector_after_next_o, i[0]);
      check(device_reset_o, 1'b0);
      @(posedge mclk_i);
      io_i <= '{out: 6'h2a, oe: 6'h0f};
    end
    @(posedge mclk_i);
    irq_flag_i <= 8'h00;
    rd_chk(A_STS, 32'h02);
    // pin low while asleep must reset, not continue
    enter_sleep();
    @(posedge mclk_i);
    master_clear_pin_i <= 1'b0;
    wait_sig(1, 10, n);
    check(wake_continue_o, 1'b0);
    @(posedge mclk_i);
    master_clear_pin_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    // crystal wake parks in start-up; a pin reset cuts it short
    @(posedge mclk_i);
    crystal_mode_i <= 1'b1;
    enter_sleep();
    @(posedge mclk_i);
    irq_flag_i <= 8'h80;
    repeat (3) @(posedge mclk_i);
    #1;
    check(core_run_o, 1'b0);
    check(wake_continue_o, 1'b0);
    rd_chk(A_STS, 32'h0a);
    master_clear_pin_i <= 1'b0;
    wait_sig(1, 10, n);
    check(core_run_o, 1'b1);
    @(posedge mclk_i);
    master_clear_pin_i <= 1'b1;
    crystal_mode_i <= 1'b0;
    irq_flag_i <= 8'h00;
    repeat (6) @(posedge mclk_i);
    // shortest period: 32 low-frequency ticks, then a continuing wake
    wr(A_CTL, 32'h01);
    @(posedge mclk_i);
    clear_watchdog_instr_i <= 1'b1;
    @(posedge mclk_i);
    clear_watchdog_instr_i <= 1'b0;
    enter_sleep();
    wait_sig(0, 45000, n);
    check(32'(n > (1 << PSEL_BASE_LOG2) * TICK - TICK), 32'h1);
    check(vector_after_next_o, 1'b0);
    check(wdt_expiry_flag_o, 1'b0);
    check(device_reset_o, 1'b0);
    check(32'(n <= (1 << PSEL_BASE_LOG2) * TICK + 4), 32'h1);
    // left awake on the short period, the next overflow resets the device
    wait_sig(1, 45000, n);
    check(32'(n > (1 << PSEL_BASE_LOG2) * TICK - TICK), 32'h1);
    check(wake_continue_o, 1'b0);
    finish_test();
  end
endmodule : watchdog_sleep_wake_control_tb
